/* File: hw/dsca_core.sv */
/*
 * Memory core access logic: command decode, eight-bank row state, burst
 * engines for read and write, a small flip-flop storage array and an APB
 * slave for control and status.
 * Assumes the link pins are synchronous to mem_clk_i and that each pin pair
 * carries the rising-half and falling-half value of one link clock cycle.
 */
`timescale 1ns/1ps
`default_nettype none
module dsca_core (
	input  wire logic                              sys_clk_i,
	input  wire logic                              arst_n_i,
	input  wire logic                              mem_clk_i,
	input  wire logic                              psel_i,
	input  wire logic                              penable_i,
	input  wire logic                              pwrite_i,
	input  wire logic [dsca_pkg::APB_ADDR_W-1:0]   paddr_i,
	input  wire logic [31:0]                       pwdata_i,
	input  wire logic [3:0]                        pstrb_i,
	output logic      [31:0]                       prdata_o,
	output logic                                   pready_o,
	output logic                                   pslverr_o,
	input  wire logic                              cke_i,
	input  wire logic                              cs_n_i,
	input  wire logic                              ras_n_i,
	input  wire logic                              cas_n_i,
	input  wire logic                              we_n_i,
	input  wire logic [dsca_pkg::BANK_W-1:0]       bank_i,
	input  wire logic [dsca_pkg::ADDR_W-1:0]       addr_i,
	input  wire logic [dsca_pkg::NARROW_W-1:0]     dq_rise_i,
	input  wire logic [dsca_pkg::NARROW_W-1:0]     dq_fall_i,
	input  wire logic                              dm_rise_i,
	input  wire logic                              dm_fall_i,
	input  wire logic                              dqs_rise_i,
	output logic      [dsca_pkg::NARROW_W-1:0]     dq_rise_o,
	output logic      [dsca_pkg::NARROW_W-1:0]     dq_fall_o,
	output logic                                   dq_oe_n_o,
	output logic                                   dqs_rise_o,
	output logic                                   dqs_fall_o,
	output logic                                   dqs_oe_n_o
);

	// ****************************************
	// functions
	// ****************************************
	function automatic logic [2:0] burst_index(input logic [2:0] start,
		input logic [2:0] k, input logic ilv);
		logic [1:0] low;
		low = start[1:0] + k[1:0];
		burst_index = ilv ? (start ^ k) : {start[2] ^ k[2], low};
	endfunction

	function automatic logic [dsca_pkg::LAT_W-1:0] lat_tap(
		input logic [dsca_pkg::LAT_W-1:0] lat);
		lat_tap = (lat < dsca_pkg::LAT_OFFSET) ? '0 : lat - dsca_pkg::LAT_OFFSET;
	endfunction

	// ****************************************
	// apb slave, system clock
	// ****************************************
	logic [dsca_pkg::CTRL_W-1:0] ctrl_q;
	logic [dsca_pkg::STAT_W-1:0] stat_s1_q;
	logic [dsca_pkg::STAT_W-1:0] stat_s2_q;
	logic                        hit_ctrl_w;
	logic                        hit_stat_w;
	logic [31:0]                 ctrl_wide_w;

	assign hit_ctrl_w  = paddr_i == dsca_pkg::ADDR_CTRL;
	assign hit_stat_w  = paddr_i == dsca_pkg::ADDR_STATUS;
	assign ctrl_wide_w = 32'(ctrl_q);

	// answer one cycle after setup: no wait states
	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			pready_o  <= 1'b0;
			pslverr_o <= 1'b0;
			prdata_o  <= 32'h0000_0000;
		end else begin
			pready_o <= psel_i & ~penable_i;
			pslverr_o <= 1'b0;
			if (psel_i && !penable_i) begin
				pslverr_o <= ~(hit_ctrl_w | hit_stat_w);
				if (hit_ctrl_w)
					prdata_o <= ctrl_wide_w;
				else if (hit_stat_w)
					prdata_o <= 32'(stat_s2_q);
				else
					prdata_o <= 32'h0000_0000;
			end
		end
	end

	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ctrl_q <= dsca_pkg::CTRL_RESET;
		end else if (psel_i && penable_i && pready_o && pwrite_i && hit_ctrl_w) begin
			if (pstrb_i[0])
				ctrl_q[dsca_pkg::CTRL_WL_LSB-1:0] <= pwdata_i[dsca_pkg::CTRL_WL_LSB-1:0] &
					dsca_pkg::CTRL_MASK[dsca_pkg::CTRL_WL_LSB-1:0];
			if (pstrb_i[1])
				ctrl_q[dsca_pkg::CTRL_W-1:dsca_pkg::CTRL_WL_LSB] <=
					pwdata_i[dsca_pkg::CTRL_W-1:dsca_pkg::CTRL_WL_LSB];
		end
	end

	// ****************************************
	// domain crossings
	// ****************************************
	logic [dsca_pkg::CTRL_W-1:0] ctrl_s1_q;
	logic [dsca_pkg::CTRL_W-1:0] ctrl_s2_q;
	logic [dsca_pkg::STAT_W-1:0] stat_w;

	// bits are independent levels; change control only while the link is idle
	always_ff @(posedge mem_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ctrl_s1_q <= dsca_pkg::CTRL_RESET;
			ctrl_s2_q <= dsca_pkg::CTRL_RESET;
		end else begin
			ctrl_s1_q <= ctrl_q;
			ctrl_s2_q <= ctrl_s1_q;
		end
	end

	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			stat_s1_q <= '0;
			stat_s2_q <= '0;
		end else begin
			stat_s1_q <= stat_w;
			stat_s2_q <= stat_s1_q;
		end
	end

	logic [1:0]                 bl_mode_w;
	logic                       ilv_w;
	logic [dsca_pkg::LAT_W-1:0] rl_w;
	logic [dsca_pkg::LAT_W-1:0] wl_w;

	assign bl_mode_w = ctrl_s2_q[dsca_pkg::CTRL_BL_LSB +: 2];
	assign ilv_w     = ctrl_s2_q[dsca_pkg::CTRL_ILV_BIT];
	assign rl_w      = ctrl_s2_q[dsca_pkg::CTRL_RL_LSB +: dsca_pkg::LAT_W];
	assign wl_w      = ctrl_s2_q[dsca_pkg::CTRL_WL_LSB +: dsca_pkg::LAT_W];

	// ****************************************
	// command sampling, link clock
	// ****************************************
	logic                          cke_q;
	logic                          cke_prev_q;
	logic                          cs_n_q;
	logic [2:0]                    cmd_pins_q;
	logic [dsca_pkg::BANK_W-1:0]   bank_q;
	logic [dsca_pkg::ADDR_W-1:0]   addr_q;
	logic [dsca_pkg::NARROW_W-1:0] dq_rise_q;
	logic [dsca_pkg::NARROW_W-1:0] dq_fall_q;
	logic                          dm_rise_q;
	logic                          dm_fall_q;
	logic                          dqs_rise_q;

	always_ff @(posedge mem_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			cke_q      <= 1'b0;
			cke_prev_q <= 1'b0;
			cs_n_q     <= 1'b1;
			cmd_pins_q <= dsca_pkg::CMD_NOP;
			bank_q     <= '0;
			addr_q     <= '0;
		end else begin
			cke_q      <= cke_i;
			cke_prev_q <= cke_q;
			cs_n_q     <= cs_n_i;
			cmd_pins_q <= {ras_n_i, cas_n_i, we_n_i};
			bank_q     <= bank_i;
			addr_q     <= addr_i;
		end
	end

	// data pins are launched on the link clock; one register aligns them
	always_ff @(posedge mem_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			dq_rise_q  <= '0;
			dq_fall_q  <= '0;
			dm_rise_q  <= 1'b1;
			dm_fall_q  <= 1'b1;
			dqs_rise_q <= 1'b0;
		end else begin
			dq_rise_q  <= dq_rise_i;
			dq_fall_q  <= dq_fall_i;
			dm_rise_q  <= dm_rise_i;
			dm_fall_q  <= dm_fall_i;
			dqs_rise_q <= dqs_rise_i;
		end
	end

	// ****************************************
	// decode and bank state
	// ****************************************
	dsca_pkg::dsca_cmd_type      cmd_w;
	logic [dsca_pkg::NBANKS-1:0] open_q;
	logic [dsca_pkg::NBANKS-1:0] row_q;
	logic                        sr_q;
	logic                        pd_q;
	logic                        live_w;
	logic                        bank_open_w;
	logic                        chop_w;
	logic                        rd_ap_end_w;
	logic                        wr_commit_w;
	dsca_pkg::dsca_req_type      rd_info_q;
	dsca_pkg::dsca_req_type      wr_info_q;
	dsca_pkg::dsca_req_type      req_w;

	assign cmd_w       = cs_n_q ? dsca_pkg::CMD_NOP : dsca_pkg::dsca_cmd_type'(cmd_pins_q);
	assign live_w      = cke_q & cke_prev_q & ~sr_q & ~pd_q;
	assign bank_open_w = open_q[bank_q];
	assign chop_w      = (bl_mode_w == dsca_pkg::BL_FIXED4) ||
		((bl_mode_w == dsca_pkg::BL_OTF) && !addr_q[dsca_pkg::BC_BIT]);
	assign stat_w      = {pd_q, sr_q, open_q};

	always_comb begin
		req_w       = '0;
		req_w.rd    = live_w && cmd_w == dsca_pkg::CMD_RD && bank_open_w;
		req_w.wr    = live_w && cmd_w == dsca_pkg::CMD_WR && bank_open_w;
		req_w.bank  = bank_q;
		req_w.idx   = {bank_q, row_q[bank_q],
			addr_q[dsca_pkg::COL_GRP_LSB +: dsca_pkg::COL_GRP_W]};
		req_w.start = addr_q[2:0];
		req_w.chop  = chop_w;
		req_w.ap    = addr_q[dsca_pkg::AP_BIT];
	end

	// each bank keeps its own row, so work in one overlaps bursts in another
	always_ff @(posedge mem_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			open_q <= '0;
			row_q  <= '0;
		end else begin
			if (live_w && cmd_w == dsca_pkg::CMD_ACT && !bank_open_w) begin
				open_q[bank_q] <= 1'b1;
				row_q[bank_q]  <= addr_q[0];
			end
			if (live_w && cmd_w == dsca_pkg::CMD_PRE) begin
				if (addr_q[dsca_pkg::AP_BIT])
					open_q <= '0;
				else
					open_q[bank_q] <= 1'b0;
			end
			if (rd_ap_end_w)
				open_q[rd_info_q.bank] <= 1'b0;
			if (wr_commit_w && wr_info_q.ap)
				open_q[wr_info_q.bank] <= 1'b0;
		end
	end

	// refresh itself is internal; only the low-power modes leave state
	always_ff @(posedge mem_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			sr_q <= 1'b0;
			pd_q <= 1'b0;
		end else if (cke_q) begin
			sr_q <= 1'b0;
			pd_q <= 1'b0;
		end else if (cke_prev_q && !sr_q && !pd_q) begin
			if (cmd_w == dsca_pkg::CMD_REF && open_q == '0)
				sr_q <= 1'b1;
			else
				pd_q <= 1'b1;
		end
	end

	// ****************************************
	// latency pipeline
	// ****************************************
	dsca_pkg::dsca_req_type pipe_q [dsca_pkg::PIPE_DEPTH];
	dsca_pkg::dsca_req_type rd_tap_w;
	dsca_pkg::dsca_req_type wr_tap_w;

	always_ff @(posedge mem_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			for (int i = 0; i < dsca_pkg::PIPE_DEPTH; i++)
				pipe_q[i] <= '0;
		end else begin
			pipe_q[0] <= req_w;
			for (int i = 1; i < dsca_pkg::PIPE_DEPTH; i++)
				pipe_q[i] <= pipe_q[i-1];
		end
	end

	assign rd_tap_w = pipe_q[lat_tap(rl_w)];
	assign wr_tap_w = pipe_q[lat_tap(wl_w)];

	// ****************************************
	// storage
	// ****************************************
	logic [dsca_pkg::WIDE_W-1:0] mem_q [dsca_pkg::MEM_DEPTH];
	logic [dsca_pkg::WIDE_W-1:0] rd_order_w;
	logic [dsca_pkg::WIDE_W-1:0] wr_word_q;
	logic [dsca_pkg::WORD_BEATS-1:0] wr_en_q;

	// one wide core word per access, laid out in burst order
	always_comb begin
		rd_order_w = '0;
		for (int k = 0; k < dsca_pkg::WORD_BEATS; k++)
			rd_order_w[k*dsca_pkg::NARROW_W +: dsca_pkg::NARROW_W] =
				mem_q[rd_tap_w.idx][burst_index(rd_tap_w.start, 3'(k), ilv_w)
				* dsca_pkg::NARROW_W +: dsca_pkg::NARROW_W];
	end

	always_ff @(posedge mem_clk_i) begin
		if (wr_commit_w) begin
			for (int b = 0; b < dsca_pkg::WORD_BEATS; b++)
				if (wr_en_q[b])
					mem_q[wr_info_q.idx][b*dsca_pkg::NARROW_W +: dsca_pkg::NARROW_W] <=
						wr_word_q[b*dsca_pkg::NARROW_W +: dsca_pkg::NARROW_W];
		end
	end

	// ****************************************
	// read burst engine
	// ****************************************
	dsca_pkg::dsca_state_type    rd_state_q;
	logic [2:0]                  rd_cnt_q;
	logic [dsca_pkg::WIDE_W-1:0] rd_word_q;
	logic                        rd_load_w;

	// reads need a gap of two cycles between bursts; a tap while busy is dropped
	assign rd_load_w   = rd_tap_w.rd &&
		(rd_state_q == dsca_pkg::ST_IDLE || rd_state_q == dsca_pkg::ST_POST);
	assign rd_ap_end_w = rd_state_q == dsca_pkg::ST_DATA && rd_cnt_q == 3'h0 && rd_info_q.ap;

	always_ff @(posedge mem_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rd_state_q <= dsca_pkg::ST_IDLE;
			rd_cnt_q   <= 3'h0;
			rd_word_q  <= '0;
			rd_info_q  <= '0;
			dq_rise_o  <= '0;
			dq_fall_o  <= '0;
			dq_oe_n_o  <= 1'b1;
			dqs_rise_o <= 1'b0;
			dqs_fall_o <= 1'b0;
			dqs_oe_n_o <= 1'b1;
		end else begin
			unique case (rd_state_q)
				dsca_pkg::ST_IDLE: begin
					dqs_oe_n_o <= 1'b1;
				end
				dsca_pkg::ST_PRE, dsca_pkg::ST_DATA: begin
					if (rd_state_q == dsca_pkg::ST_PRE || rd_cnt_q != 3'h0) begin
						rd_state_q <= dsca_pkg::ST_DATA;
						dq_rise_o  <= rd_word_q[0 +: dsca_pkg::NARROW_W];
						dq_fall_o  <= rd_word_q[dsca_pkg::NARROW_W +: dsca_pkg::NARROW_W];
						rd_word_q  <= rd_word_q >> (2 * dsca_pkg::NARROW_W);
						rd_cnt_q   <= rd_cnt_q - 3'h1;
						dq_oe_n_o  <= 1'b0;
						dqs_rise_o <= 1'b1;
						dqs_fall_o <= 1'b0;
					end else begin
						rd_state_q <= dsca_pkg::ST_POST;
						dq_oe_n_o  <= 1'b1;
						dqs_rise_o <= 1'b0;
						dqs_fall_o <= 1'b0;
					end
				end
				dsca_pkg::ST_POST: begin
					rd_state_q <= dsca_pkg::ST_IDLE;
					dqs_oe_n_o <= 1'b1;
				end
			endcase
			if (rd_load_w) begin
				rd_state_q <= dsca_pkg::ST_PRE;
				rd_info_q  <= rd_tap_w;
				rd_word_q  <= rd_order_w;
				rd_cnt_q   <= rd_tap_w.chop ? 3'(dsca_pkg::CYC_BC4) : 3'(dsca_pkg::CYC_BL8);
				dqs_oe_n_o <= 1'b0;
				dqs_rise_o <= 1'b0;
				dqs_fall_o <= 1'b0;
			end
		end
	end

	// ****************************************
	// write burst engine
	// ****************************************
	dsca_pkg::dsca_state_type wr_state_q;
	logic [2:0]     wr_beat_q;
	logic [2:0]     wr_wait_q;
	logic [3:0]     wr_total_w;
	logic [2:0]     pos_a_w;
	logic [2:0]     pos_b_w;
	logic           wr_last_w;

	assign wr_commit_w = wr_state_q == dsca_pkg::ST_POST;
	assign wr_total_w  = wr_info_q.chop ? 4'(dsca_pkg::BEATS_BC4) : 4'(dsca_pkg::WORD_BEATS);
	assign wr_last_w   = ({1'b0, wr_beat_q} + 4'h2) == wr_total_w;
	assign pos_a_w     = burst_index(wr_info_q.start, wr_beat_q, ilv_w);
	assign pos_b_w     = burst_index(wr_info_q.start, wr_beat_q + 3'h1, ilv_w);

	// a strobe that never rises after the preamble abandons the burst
	always_ff @(posedge mem_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			wr_state_q <= dsca_pkg::ST_IDLE;
			wr_beat_q  <= 3'h0;
			wr_wait_q  <= 3'h0;
			wr_info_q  <= '0;
			wr_word_q  <= '0;
			wr_en_q    <= '0;
		end else begin
			unique case (wr_state_q)
				dsca_pkg::ST_IDLE: begin
					if (wr_tap_w.wr) begin
						wr_state_q <= dsca_pkg::ST_PRE;
						wr_info_q  <= wr_tap_w;
						wr_beat_q  <= 3'h0;
						wr_wait_q  <= 3'h0;
						wr_en_q    <= '0;
					end
				end
				dsca_pkg::ST_PRE, dsca_pkg::ST_DATA: begin
					if (wr_state_q == dsca_pkg::ST_DATA || dqs_rise_q) begin
						wr_word_q[pos_a_w*dsca_pkg::NARROW_W +: dsca_pkg::NARROW_W] <= dq_rise_q;
						wr_word_q[pos_b_w*dsca_pkg::NARROW_W +: dsca_pkg::NARROW_W] <= dq_fall_q;
						wr_en_q[pos_a_w] <= ~dm_rise_q;
						wr_en_q[pos_b_w] <= ~dm_fall_q;
						wr_beat_q  <= wr_beat_q + 3'h2;
						wr_state_q <= wr_last_w ? dsca_pkg::ST_POST : dsca_pkg::ST_DATA;
					end else if (wr_wait_q == dsca_pkg::WR_WAIT_MAX) begin
						wr_state_q <= dsca_pkg::ST_IDLE;
					end else begin
						wr_wait_q <= wr_wait_q + 3'h1;
					end
				end
				dsca_pkg::ST_POST: begin
					wr_state_q <= dsca_pkg::ST_IDLE;
				end
			endcase
		end
	end

endmodule
`default_nettype wire

/* File: hw/dsca_pkg.sv */
/*
 * Constants, types and register map for the memory core access block.
 * Assumes one module of the block uses it, naming everything by package scope.
 */
// Notes on behaviour
// - one wide word becomes eight narrow half-clock words
// - device drives read data edge-aligned with strobe
// - command and address sampled each positive edge
// - first write word on first rising strobe
// - first read word on first rising strobe
// - activate opens bank and row first
// - read or write picks bank and column
// - burst runs programmed length in programmed order
// - full burst of eight or chop of four
// - auto precharge closes row at burst end
// - banks work independently and overlap
// - self refresh and power-down modes exist
// - row address top index set by density
// - eight banks chosen by bank address
`default_nettype none
package dsca_pkg;

	// ****************************************
	// link geometry
	// ****************************************
	localparam int NARROW_W   = 8;
	localparam int WORD_BEATS = 8;
	localparam int WIDE_W     = NARROW_W * WORD_BEATS;
	localparam int BEATS_BC4  = 4;
	localparam int CYC_BL8    = 4;
	localparam int CYC_BC4    = 2;
	localparam int BANK_W     = 3;
	localparam int NBANKS     = 8;
	localparam int ROW_TOP    = 13;
	localparam int ADDR_W     = ROW_TOP + 1;
	localparam int AP_BIT     = 10;
	localparam int BC_BIT     = 12;
	localparam int COL_GRP_LSB = 3;
	localparam int COL_GRP_W  = 2;
	localparam int MEM_IDX_W  = BANK_W + 1 + COL_GRP_W;
	localparam int MEM_DEPTH  = 1 << MEM_IDX_W;
	localparam int LAT_W      = 4;
	localparam int PIPE_DEPTH = 1 << LAT_W;
	localparam logic [LAT_W-1:0] LAT_OFFSET = 4'h3;
	localparam logic [2:0] WR_WAIT_MAX = 3'h4;

	// ****************************************
	// apb register map
	// ****************************************
	localparam int APB_ADDR_W = 12;
	localparam logic [APB_ADDR_W-1:0] ADDR_CTRL   = 12'h000;
	localparam logic [APB_ADDR_W-1:0] ADDR_STATUS = 12'h004;
	localparam int CTRL_BL_LSB  = 0;
	localparam int CTRL_ILV_BIT = 2;
	localparam int CTRL_RL_LSB  = 4;
	localparam int CTRL_WL_LSB  = 8;
	localparam int CTRL_W       = 12;
	localparam logic [CTRL_W-1:0] CTRL_RESET = 12'h561;
	localparam logic [31:0] CTRL_MASK = 32'h0000_0FF7;
	localparam int STAT_OPEN_LSB = 0;
	localparam int STAT_SR_BIT   = 8;
	localparam int STAT_PD_BIT   = 9;
	localparam int STAT_W        = 10;

	localparam logic [1:0] BL_FIXED8 = 2'h0;
	localparam logic [1:0] BL_OTF    = 2'h1;
	localparam logic [1:0] BL_FIXED4 = 2'h2;

	// ****************************************
	// types
	// ****************************************
	typedef enum logic [2:0] {
		CMD_MRS  = 3'h0,
		CMD_REF  = 3'h1,
		CMD_PRE  = 3'h2,
		CMD_ACT  = 3'h3,
		CMD_WR   = 3'h4,
		CMD_RD   = 3'h5,
		CMD_ZQ   = 3'h6,
		CMD_NOP  = 3'h7
	} dsca_cmd_type;

	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_PRE  = 2'h1,
		ST_DATA = 2'h3,
		ST_POST = 2'h2
	} dsca_state_type;

	typedef struct packed {
		logic                 rd;
		logic                 wr;
		logic [BANK_W-1:0]    bank;
		logic [MEM_IDX_W-1:0] idx;
		logic [2:0]           start;
		logic                 chop;
		logic                 ap;
	} dsca_req_type;

endpackage
`default_nettype wire

/* File: sim/dsca_core_assertions.sv */
/* Checker for the core access block: apb handshake and read strobe framing.
 * Assumes it is bound to dsca_core and sees only that module's ports. */
`timescale 1ns/1ps
`default_nettype none
module dsca_core_chk (
	input wire logic sys_clk_i,
	input wire logic arst_n_i,
	input wire logic mem_clk_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pready_o,
	input wire logic pslverr_o,
	input wire logic dq_oe_n_o,
	input wire logic dqs_rise_o,
	input wire logic dqs_fall_o,
	input wire logic dqs_oe_n_o
);
	// ****************
	// apb handshake
	// ****************
	a_ready_after_setup: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
		psel_i && !penable_i |=> pready_o) else $error("pready late");
	a_ready_one_cycle: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
		pready_o |=> !pready_o) else $error("pready too long");
	a_err_needs_ready: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
		pslverr_o |-> pready_o) else $error("pslverr without pready");
	a_ready_cause: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
		$rose(pready_o) |-> $past(psel_i) && !$past(penable_i)) else $error("pready uncaused");
	// ****************
	// read framing
	// ****************
	a_pre_then_data: assert property (@(posedge mem_clk_i) disable iff (!arst_n_i)
		$fell(dqs_oe_n_o) |-> dq_oe_n_o && !dqs_rise_o && !dqs_fall_o ##1 !dq_oe_n_o)
		else $error("bad read preamble");
	a_edge_aligned: assert property (@(posedge mem_clk_i) disable iff (!arst_n_i)
		!dq_oe_n_o |-> !dqs_oe_n_o && dqs_rise_o && !dqs_fall_o)
		else $error("strobe not with data");
	a_burst_len: assert property (@(posedge mem_clk_i) disable iff (!arst_n_i)
		$fell(dq_oe_n_o) |-> !dq_oe_n_o[*2] ##1 (dq_oe_n_o or (!dq_oe_n_o[*2] ##1 dq_oe_n_o)))
		else $error("read burst length wrong");
	a_postamble: assert property (@(posedge mem_clk_i) disable iff (!arst_n_i)
		$rose(dq_oe_n_o) |-> !dqs_oe_n_o && !dqs_rise_o && !dqs_fall_o ##1 dq_oe_n_o)
		else $error("bad read postamble");
	a_data_needs_strobe: assert property (@(posedge mem_clk_i) disable iff (!arst_n_i)
		dqs_oe_n_o |-> dq_oe_n_o) else $error("data without strobe");
	c_err: cover property (@(posedge sys_clk_i) pslverr_o);
	c_read: cover property (@(posedge mem_clk_i) $fell(dq_oe_n_o));
	c_chop: cover property (@(posedge mem_clk_i) $fell(dq_oe_n_o) ##2 dq_oe_n_o);
endmodule
bind dsca_core dsca_core_chk chk_u (.*);
`default_nettype wire

/* File: sim/dsca_ctrl_model.sv */
/* Controller-side model of the memory link: commands, write bursts with
 * strobe, and read burst capture. Assumes mem_clk_i runs free. */
`timescale 1ns/1ps
`default_nettype none
module dsca_ctrl_model (
	input  wire logic                          mem_clk_i,
	output logic                               cke_o,
	output logic                               cs_n_o,
	output logic                               ras_n_o,
	output logic                               cas_n_o,
	output logic                               we_n_o,
	output logic [dsca_pkg::BANK_W-1:0]        bank_o,
	output logic [dsca_pkg::ADDR_W-1:0]        addr_o,
	output logic [dsca_pkg::NARROW_W-1:0]      dq_rise_o,
	output logic [dsca_pkg::NARROW_W-1:0]      dq_fall_o,
	output logic                               dm_rise_o,
	output logic                               dm_fall_o,
	output logic                               dqs_rise_o,
	input  wire logic [dsca_pkg::NARROW_W-1:0] dq_rise_i,
	input  wire logic [dsca_pkg::NARROW_W-1:0] dq_fall_i,
	input  wire logic                          dq_oe_n_i,
	input  wire logic                          dqs_rise_i,
	input  wire logic                          dqs_fall_i,
	input  wire logic                          dqs_oe_n_i
);
	logic busy;
	initial begin
		{cke_o, dm_rise_o, dm_fall_o, dqs_rise_o, busy} = 5'h00;
		{cs_n_o, ras_n_o, cas_n_o, we_n_o} = 4'hF;
		bank_o = 3'h0;
		addr_o = 14'h0000;
		dq_rise_o = 8'h00;
		dq_fall_o = 8'hFF;
	end
	// released lines toggle so a stale beat never looks valid
	always @(posedge mem_clk_i) begin
		if (!busy) begin
			dq_rise_o <= ~dq_rise_o;
			dq_fall_o <= ~dq_fall_o;
		end
	end
	task automatic start();
		@(posedge mem_clk_i);
		cke_o <= 1'h1;
		repeat (3) @(posedge mem_clk_i);
	endtask
	// k is {ras_n, cas_n, we_n}; returns at the sampling edge
	task automatic cmd(input logic [2:0] k, input logic [2:0] b, input logic [13:0] a);
		@(posedge mem_clk_i);
		{cs_n_o, ras_n_o, cas_n_o, we_n_o} <= {1'h0, k};
		bank_o <= b;
		addr_o <= a;
		@(posedge mem_clk_i);
		{cs_n_o, ras_n_o, cas_n_o, we_n_o} <= 4'hF;
	endtask
	task automatic wr(input logic [2:0] b, input logic [13:0] a, input logic [63:0] d);
		cmd(3'h4, b, a);
		busy = 1'h1;
		repeat (5) @(posedge mem_clk_i);
		for (int i = 0; i < (a[12] ? 4 : 2); i++) begin
			dqs_rise_o <= 1'h1;
			dq_rise_o <= d[16*i+:8];
			dq_fall_o <= d[16*i+8+:8];
			@(posedge mem_clk_i);
		end
		dqs_rise_o <= 1'h0;
		busy = 1'h0;
	endtask
	task automatic rd(input logic [2:0] b, input logic [13:0] a, output logic [63:0] w,
			output logic ok);
		cmd(3'h5, b, a);
		w = 64'h0;
		repeat (5) @(posedge mem_clk_i);
		#1;
		ok = !dqs_oe_n_i && dq_oe_n_i && !dqs_rise_i;
		for (int i = 0; i < (a[12] ? 4 : 2); i++) begin
			@(posedge mem_clk_i);
			#1;
			ok &= !dq_oe_n_i && dqs_rise_i && !dqs_fall_i;
			w[16*i+:16] = {dq_fall_i, dq_rise_i};
		end
		@(posedge mem_clk_i);
		#1;
		ok &= dq_oe_n_i && !dqs_oe_n_i;
	endtask
endmodule
`default_nettype wire

/* File: sim/tb_top.sv */
/* Bench for the core access block: apb registers and link bursts.
 * Assumes the controller model drives the link pins. */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic        sys_clk_i, mem_clk_i, arst_n_i, ok, ilv;
	logic        psel, penable, pwrite, pready, pslverr;
	logic        cke, cs_n, ras_n, cas_n, we_n, dm_r, dm_f, dqs_i;
	logic        dq_oe_n, dqs_r, dqs_f, dqs_oe_n;
	logic [3:0]  pstrb;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, r;
	logic [2:0]  bank, bk, s;
	logic [13:0] addr, row;
	logic [7:0]  dqr_i, dqf_i, dqr_o, dqf_o;
	logic [63:0] mw, d2, got;
	int          n_fail, checks;
	dsca_core dut_u (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .mem_clk_i(mem_clk_i),
		.psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
		.pwdata_i(pwdata), .pstrb_i(pstrb), .prdata_o(prdata), .pready_o(pready),
		.pslverr_o(pslverr), .cke_i(cke), .cs_n_i(cs_n), .ras_n_i(ras_n), .cas_n_i(cas_n),
		.we_n_i(we_n), .bank_i(bank), .addr_i(addr), .dq_rise_i(dqr_i), .dq_fall_i(dqf_i),
		.dm_rise_i(dm_r), .dm_fall_i(dm_f), .dqs_rise_i(dqs_i), .dq_rise_o(dqr_o),
		.dq_fall_o(dqf_o), .dq_oe_n_o(dq_oe_n), .dqs_rise_o(dqs_r), .dqs_fall_o(dqs_f),
		.dqs_oe_n_o(dqs_oe_n));
	dsca_ctrl_model mc_u (.mem_clk_i(mem_clk_i), .cke_o(cke), .cs_n_o(cs_n),
		.ras_n_o(ras_n), .cas_n_o(cas_n), .we_n_o(we_n), .bank_o(bank), .addr_o(addr),
		.dq_rise_o(dqr_i), .dq_fall_o(dqf_i), .dm_rise_o(dm_r), .dm_fall_o(dm_f),
		.dqs_rise_o(dqs_i), .dq_rise_i(dqr_o), .dq_fall_i(dqf_o), .dq_oe_n_i(dq_oe_n),
		.dqs_rise_i(dqs_r), .dqs_fall_i(dqs_f), .dqs_oe_n_i(dqs_oe_n));
	// ****************
	// helpers
	// ****************
	task automatic chk(input logic [63:0] g, input logic [63:0] e, input string m);
		checks++;
		if (g !== e) begin
			n_fail++;
			$display("mismatch at %0t: %s", $time, m);
		end
	endtask
	task automatic test_done();
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
			input logic [3:0] st, input logic [31:0] ed, input logic ee);
		logic e;
		@(posedge sys_clk_i);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= st;
		@(posedge sys_clk_i);
		penable <= 1'h1;
		@(posedge sys_clk_i);
		while (pready !== 1'h1)
			@(posedge sys_clk_i);
		e = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		chk({63'h0, e}, {63'h0, ee}, "apb error response");
		if (!w) chk({32'h0, prdata}, {32'h0, ed}, "apb read data");
	endtask
	function automatic logic [2:0] bidx(input logic [2:0] s, input logic [2:0] k);
		return ilv ? s ^ k : {s[2] ^ k[2], s[1:0] + k[1:0]};
	endfunction
	function automatic logic [63:0] expw(input logic [63:0] m, input logic [2:0] s,
			input logic b8);
		logic [63:0] e;
		logic [2:0]  j;
		e = 64'h0;
		for (int k = 0; k < (b8 ? 8 : 4); k++) begin
			j = bidx(s, k[2:0]);
			e[8*k+:8] = m[8*j+:8];
		end
		return e;
	endfunction
	function automatic logic [13:0] col(input logic ap, input logic b8, input logic [2:0] s);
		return {1'h0, b8, 1'h0, ap, 5'h00, row[1:0], s};
	endfunction
	task automatic status(input logic [31:0] e);
		repeat (12) @(posedge sys_clk_i);
		apb(1'h0, dsca_pkg::ADDR_STATUS, 32'h0, 4'h0, e, 1'h0);
	endtask
	// ****************
	// stimulus
	// ****************
	initial begin
		sys_clk_i = 1'h0;
		forever #2.5 sys_clk_i = ~sys_clk_i;
	end
	initial begin
		mem_clk_i = 1'h0;
		#1.3;
		forever #7.5 mem_clk_i = ~mem_clk_i;
	end
	initial begin
		repeat (20000) @(posedge sys_clk_i);
		n_fail++;
		test_done();
	end
	initial begin
		{psel, penable, pwrite, pstrb, paddr, pwdata} = 51'h0;
		{n_fail, checks} = 64'h0;
		arst_n_i = 1'h0;
		void'($urandom(73));
		repeat (3) @(posedge mem_clk_i);
		@(posedge sys_clk_i);
		arst_n_i <= 1'h1;
		apb(1'h0, dsca_pkg::ADDR_CTRL, 32'h0, 4'h0, 32'h561, 1'h0);
		r = $urandom();
		ilv = r[0];
		apb(1'h1, dsca_pkg::ADDR_CTRL, {20'h0, 8'hA6, 1'h1, ilv, 2'h1}, 4'h1, 32'h0, 1'h0);
		apb(1'h0, dsca_pkg::ADDR_CTRL, 32'h0, 4'h0, {20'h0, 8'h56, 1'h0, ilv, 2'h1}, 1'h0);
		apb(1'h0, 12'h008, 32'h0, 4'h0, 32'h0, 1'h1);
		apb(1'h1, dsca_pkg::ADDR_STATUS, 32'hFF, 4'hF, 32'h0, 1'h0);
		status(32'h0);
		mc_u.start();
		repeat (2) mc_u.cmd(3'h1, 3'h0, 14'h0000);
		r = $urandom();
		bk = r[2:0];
		row = r[17:4];
		mw = {$urandom(), $urandom()};
		d2 = {$urandom(), $urandom()};
		mc_u.cmd(3'h3, bk, row);
		mc_u.cmd(3'h3, bk ^ 3'h1, row);
		status(32'h1 << bk | 32'h1 << (bk ^ 3'h1));
		mc_u.wr(bk, col(1'h0, 1'h1, 3'h0), mw);
		for (int i = 0; i < 4; i++) begin
			r = $urandom();
			s = (i == 3) ? 3'h7 : r[2:0];
			mc_u.rd(bk, col(1'h0, i[0], s), got, ok);
			chk({63'h0, ok}, 64'h1, "read strobe framing");
			chk(got, expw(mw, s, i[0]), "read burst data");
		end
		mc_u.wr(bk, col(1'h1, 1'h0, 3'h0), d2);
		mw[31:0] = d2[31:0];
		status(32'h1 << (bk ^ 3'h1));
		mc_u.rd(bk, col(1'h0, 1'h1, 3'h0), got, ok);
		chk({63'h0, ok}, 64'h0, "read of closed bank");
		mc_u.cmd(3'h3, bk, row);
		mc_u.rd(bk, col(1'h0, 1'h1, 3'h0), got, ok);
		chk(got, mw, "chopped write merge");
		test_done();
	end
endmodule
`default_nettype wire
